// ### shared/rtdsc_pkg.sv
package rtdsc_pkg;
	// =========================================================
	// Geometry
	localparam int NUM_CH  = 8;
	localparam int CH_W    = 3;
	localparam int ADC_W   = 14;
	localparam int TEMP_W  = 16;
	localparam int GRP_W   = 3;
	localparam int KEY_W   = 8;
	localparam int SLOT_AW = 4;
	localparam int SLOT_N  = 16;

	// =========================================================
	// Timing
	localparam longint CLK_HZ         = 100_000_000;
	localparam longint CAL_PERIOD_S   = 60;
	localparam longint CAL_PERIOD_CYC = CAL_PERIOD_S * CLK_HZ;
	localparam int     CAL_TMR_W      = 33;

	// =========================================================
	// Converter source select
	localparam logic [1:0] SEL_INPUT = 2'h0;
	localparam logic [1:0] SEL_REF_A = 2'h1;
	localparam logic [1:0] SEL_REF_B = 2'h2;

	// =========================================================
	// Reference limits and calibration
	localparam logic [13:0] REF_A_NOM  = 14'h1000;
	localparam logic [13:0] REF_B_NOM  = 14'h2800;
	localparam logic [13:0] REF_TOL    = 14'h0200;
	localparam int          SCL_FRAC   = 12;
	localparam logic [15:0] SCL_UNITY  = 16'h1000;
	localparam logic [24:0] CAL_NUM    = 25'(REF_B_NOM - REF_A_NOM) << SCL_FRAC;
	localparam logic [4:0]  DIV_STEPS  = 5'h19;
	localparam logic [13:0] CODE_MAX   = 14'h3FFF;

	// =========================================================
	// Linearisation: code LSB is 1/512 ohm, result LSB is 0.1 degC
	localparam int RES_STEPS_PER_OHM = 512;
	localparam int T_GAIN_X100       = 2595;
	localparam int T_OFS_X10         = 2345;
	localparam int SLOPE_NUM         = 519;
	localparam int SLOPE_SH          = 10;
	localparam int LUT_SEG_SH        = 6;
	localparam int LUT_N             = 256;

	// =========================================================
	// Result memory layout
	localparam int          SLOT_TEMP_OFS  = 0;
	localparam int          SLOT_STAT_OFS  = 1;
	localparam int          STAT_FAULT_BIT = 0;
	localparam logic [15:0] SLOT_RESET     = 16'h0000;

	localparam int LAG_TAU_MIN_X1000 = 200;

	typedef logic signed [15:0] rtdsc_lut_t [0:LUT_N-1];

	function automatic rtdsc_lut_t rtdsc_lut_build();
		rtdsc_lut_t lut;
		for (int i = 0; i < LUT_N; i++)
		begin
			lut[i] = 16'((((i << LUT_SEG_SH) * SLOPE_NUM) >> SLOPE_SH) - T_OFS_X10);
		end
		return lut;
	endfunction : rtdsc_lut_build
endpackage : rtdsc_pkg

// ### shared/rtdsc_if.sv
interface rtdsc_if;
	logic        cfg_wr;
	logic [2:0]  cfg_ch;
	logic [2:0]  cfg_grp;
	logic        init_done;
	logic        host_led_req;
	logic        key_stb;
	logic [7:0]  key;
	logic        rd_en;
	logic [3:0]  rd_addr;
	logic [15:0] rd_data;
	logic        rd_ack;
	logic        fault_led;

	modport dev (input cfg_wr, cfg_ch, cfg_grp, init_done, host_led_req, key_stb, key,
		rd_en, rd_addr, output rd_data, rd_ack, fault_led);
	modport host (output cfg_wr, cfg_ch, cfg_grp, init_done, host_led_req, key_stb, key,
		rd_en, rd_addr, input rd_data, rd_ack, fault_led);
endinterface : rtdsc_if

// ### hdl/rtdsc_dev.sv
module rtdsc_dev #(
	parameter longint CAL_PERIOD_CYC = rtdsc_pkg::CAL_PERIOD_CYC
) (
	input  wire logic        clock,      // System clock
	input  wire logic        resetn,     // Sync reset
	rtdsc_if.dev             bus,        // Host side
	output logic [2:0]       chan_sel,   // Channel switch select
	output logic [1:0]       ref_sel,    // Input or reference
	output logic             conv_start, // Convert pulse
	input  wire logic        adc_valid,  // Conversion done
	input  wire logic [13:0] adc_data    // Converter code
);
	// =========================================================
	// State
	typedef enum logic [3:0] {
		ST_IDLE, ST_SCAN_SEL, ST_SCAN_WAIT, ST_SCAN_CORR, ST_SCAN_LIN,
		ST_CAL_SEL, ST_CAL_WAIT, ST_CAL_DIV, ST_CAL_FIN
	} rtdsc_st_e;

	typedef struct packed {
		rtdsc_st_e       st;
		logic [2:0]      ch;
		logic            ph_b;
		logic            post_done;
		logic            post_ok;
		logic            pass_ok;
		logic [7:0]      key_pend;
		logic [7:0]      due;
		logic [32:0]     cal_tmr;
		logic            cal_due;
		logic [13:0]     raw;
		logic [13:0]     raw_a;
		logic [13:0]     corr;
		logic [13:0]     div_d;
		logic [14:0]     div_r;
		logic [24:0]     div_q;
		logic [4:0]      div_n;
		logic [7:0][2:0] grp;
		logic [7:0][15:0] scale;
		logic [7:0][15:0] ofs;
		logic [15:0][15:0] mem;
		logic            led;
		logic [2:0]      chan_sel;
		logic [1:0]      ref_sel;
		logic            conv_start;
		logic [15:0]     rd_data;
		logic            rd_ack;
	} rtdsc_dev_s;

	localparam rtdsc_pkg::rtdsc_lut_t LUT = rtdsc_pkg::rtdsc_lut_build();

	rtdsc_dev_s q;
	rtdsc_dev_s d;

	// =========================================================
	// Datapath helpers
	logic [29:0]        prod;
	logic signed [19:0] corr_s;
	logic [2:0]         first_due;
	logic [7:0]         due_new;
	logic [14:0]        div_sh;
	logic               in_lim;
	logic [13:0]        nom;
	logic [29:0]        prod_a;
	logic [15:0]        lin;

	always_comb
	begin
		prod      = 30'(q.raw) * 30'(q.scale[q.ch]);
		corr_s    = 20'(prod >> rtdsc_pkg::SCL_FRAC) + 20'(signed'(q.ofs[q.ch]));
		prod_a    = 30'(q.raw_a) * 30'(q.div_q[15:0]);
		// Segment base plus in-segment slope; copper law in 0.1 degC
		lin       = 16'(LUT[q.corr[13:6]])
			+ 16'((20'(q.corr[5:0]) * 20'(rtdsc_pkg::SLOPE_NUM)) >> rtdsc_pkg::SLOPE_SH);
		first_due = 3'h0;
		for (int i = rtdsc_pkg::NUM_CH - 1; i >= 0; i--)
		begin
			if (q.due[i])
				first_due = 3'(i);
		end
		for (int i = 0; i < rtdsc_pkg::NUM_CH; i++)
		begin
			due_new[i] = q.key_pend[q.grp[i]];
		end
		div_sh = {q.div_r[13:0], q.div_q[24]};
		nom    = q.ph_b ? rtdsc_pkg::REF_B_NOM : rtdsc_pkg::REF_A_NOM;
		in_lim = (adc_data >= nom - rtdsc_pkg::REF_TOL)
			&& (adc_data <= nom + rtdsc_pkg::REF_TOL);
	end

	// =========================================================
	// Next state
	always_comb
	begin
		d            = q;
		d.conv_start = 1'b0;
		// Host read port, always served
		d.rd_ack     = bus.rd_en;
		d.rd_data    = q.mem[bus.rd_addr];
		if (bus.cfg_wr)
			d.grp[bus.cfg_ch] = bus.cfg_grp;
		// Minute timer
		if (q.cal_tmr == 33'(CAL_PERIOD_CYC - 1))
		begin
			d.cal_tmr = '0;
		end
		else
		begin
			d.cal_tmr = q.cal_tmr + 33'h000000001;
		end
		case (q.st)
			ST_IDLE:
			begin
				if (q.cal_due)
				begin
					d.cal_due = 1'b0;
					d.ch      = 3'h0;
					d.ph_b    = 1'b0;
					d.pass_ok = 1'b1;
					d.st      = ST_CAL_SEL;
				end
				else if (|q.key_pend)
				begin
					d.due      = due_new;
					d.key_pend = '0;
					d.st       = |due_new ? ST_SCAN_SEL : ST_IDLE;
				end
			end
			ST_SCAN_SEL:
			begin
				d.ch         = first_due;
				d.chan_sel   = first_due;
				d.ref_sel    = rtdsc_pkg::SEL_INPUT;
				d.conv_start = 1'b1;
				d.st         = ST_SCAN_WAIT;
			end
			ST_SCAN_WAIT:
			begin
				if (adc_valid)
				begin
					d.raw = adc_data;
					d.st  = ST_SCAN_CORR;
				end
			end
			ST_SCAN_CORR:
			begin
				if (corr_s < 0)
					d.corr = '0;
				else if (corr_s > 20'(rtdsc_pkg::CODE_MAX))
					d.corr = rtdsc_pkg::CODE_MAX;
				else
					d.corr = corr_s[13:0];
				d.st = ST_SCAN_LIN;
			end
			ST_SCAN_LIN:
			begin
				d.mem[{q.ch, 1'b0}] = lin;
				d.due[q.ch]         = 1'b0;
				d.st                = (q.due & ~(8'h01 << q.ch)) != '0 ? ST_SCAN_SEL : ST_IDLE;
			end
			ST_CAL_SEL:
			begin
				d.chan_sel   = q.ch;
				d.ref_sel    = q.ph_b ? rtdsc_pkg::SEL_REF_B : rtdsc_pkg::SEL_REF_A;
				d.conv_start = 1'b1;
				d.st         = ST_CAL_WAIT;
			end
			ST_CAL_WAIT:
			begin
				if (adc_valid)
				begin
					if (!in_lim)
						d.pass_ok = 1'b0;
					if (!q.ph_b)
					begin
						d.raw_a = adc_data;
						d.mem[{q.ch, 1'b1}][rtdsc_pkg::STAT_FAULT_BIT] = !in_lim;
						d.ph_b  = 1'b1;
						d.st    = ST_CAL_SEL;
					end
					else
					begin
						if (!in_lim)
							d.mem[{q.ch, 1'b1}][rtdsc_pkg::STAT_FAULT_BIT] = 1'b1;
						d.div_d = adc_data - q.raw_a;
						d.div_q = rtdsc_pkg::CAL_NUM;
						d.div_r = '0;
						d.div_n = rtdsc_pkg::DIV_STEPS;
						d.st    = ST_CAL_DIV;
					end
				end
			end
			ST_CAL_DIV:
			begin
				// Restoring divide: scale = nominal span over measured span
				d.div_q = {q.div_q[23:0], 1'b0};
				d.div_r = div_sh;
				if (div_sh >= {1'b0, q.div_d})
				begin
					d.div_r    = div_sh - {1'b0, q.div_d};
					d.div_q[0] = 1'b1;
				end
				d.div_n = q.div_n - 5'h01;
				if (q.div_n == 5'h01)
					d.st = ST_CAL_FIN;
			end
			ST_CAL_FIN:
			begin
				// Faulted channel keeps its last good constants
				if (!q.mem[{q.ch, 1'b1}][rtdsc_pkg::STAT_FAULT_BIT])
				begin
					d.scale[q.ch] = q.div_q[15:0];
					d.ofs[q.ch]   = 16'(rtdsc_pkg::REF_A_NOM) - 16'(prod_a >> rtdsc_pkg::SCL_FRAC);
				end
				d.ph_b = 1'b0;
				d.ch   = q.ch + 3'h1;
				d.st   = ST_CAL_SEL;
				if (q.ch == 3'h7)
				begin
					d.st = ST_IDLE;
					if (!q.post_done)
					begin
						d.post_done = 1'b1;
						d.post_ok   = q.pass_ok;
					end
				end
			end
			default:
			begin
				d.st = ST_IDLE;
			end
		endcase
		// Events win over the clears above
		if (q.cal_tmr == 33'(CAL_PERIOD_CYC - 1))
			d.cal_due = 1'b1;
		if (bus.key_stb)
			d.key_pend = d.key_pend | bus.key;
		d.led = !(q.post_done && q.post_ok && bus.init_done && !bus.host_led_req);
	end

	// =========================================================
	// Registers
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			q         <= '0;
			q.st      <= ST_CAL_SEL;
			q.pass_ok <= 1'b1;
			q.led     <= 1'b1;
			for (int i = 0; i < rtdsc_pkg::NUM_CH; i++)
			begin
				q.scale[i] <= rtdsc_pkg::SCL_UNITY;
			end
		end
		else
		begin
			q <= d;
		end
	end

	assign chan_sel      = q.chan_sel;
	assign ref_sel       = q.ref_sel;
	assign conv_start    = q.conv_start;
	assign bus.rd_data   = q.rd_data;
	assign bus.rd_ack    = q.rd_ack;
	assign bus.fault_led = q.led;
endmodule : rtdsc_dev

// ### hdl/rtdsc_host.sv
module rtdsc_host (
	input  wire logic        clock,        // System clock
	input  wire logic        resetn,       // Sync reset
	rtdsc_if.host            bus,          // Card side
	input  wire logic        cfg_wr_in,    // Group write
	input  wire logic [2:0]  cfg_ch_in,    // Channel
	input  wire logic [2:0]  cfg_grp_in,   // Rate group
	input  wire logic        init_go,      // Card init complete
	input  wire logic        diag_done,    // Diagnostics finished
	input  wire logic        diag_pass,    // Diagnostics result
	input  wire logic        key_stb_in,   // Broadcast key
	input  wire logic [7:0]  key_in,       // Due group mask
	input  wire logic        rd_en_in,     // Read slot
	input  wire logic [3:0]  rd_addr_in,   // Slot address
	output logic [15:0]      rd_data_out,  // Slot data
	output logic             rd_ack_out,   // Data valid
	output logic             fault_led,    // Indicator state
	input  wire logic [15:0] lag_tau_in,   // Requested tau x1000
	output logic [15:0]      lag_tau_out   // Applied tau x1000
);
	// =========================================================
	// State
	typedef struct packed {
		logic        cfg_wr;
		logic [2:0]  cfg_ch;
		logic [2:0]  cfg_grp;
		logic        init_done;
		logic        led_req;
		logic        key_stb;
		logic [7:0]  key;
		logic        rd_en;
		logic [3:0]  rd_addr;
		logic [15:0] rd_data;
		logic        rd_ack;
		logic        fault_led;
		logic [15:0] lag_tau;
	} rtdsc_host_s;

	rtdsc_host_s q;
	rtdsc_host_s d;

	always_comb
	begin
		d           = q;
		d.cfg_wr    = cfg_wr_in;
		d.cfg_ch    = cfg_ch_in;
		d.cfg_grp   = cfg_grp_in;
		d.key_stb   = key_stb_in;
		d.key       = key_in;
		d.rd_en     = rd_en_in;
		d.rd_addr   = rd_addr_in;
		d.rd_data   = bus.rd_data;
		d.rd_ack    = bus.rd_ack;
		d.fault_led = bus.fault_led;
		if (init_go)
			d.init_done = 1'b1;
		if (diag_done)
			d.led_req = !diag_pass;
		d.lag_tau = lag_tau_in < 16'(rtdsc_pkg::LAG_TAU_MIN_X1000)
			? 16'(rtdsc_pkg::LAG_TAU_MIN_X1000) : lag_tau_in;
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			q         <= '0;
			q.led_req <= 1'b1;
			q.fault_led <= 1'b1;
			q.lag_tau <= 16'(rtdsc_pkg::LAG_TAU_MIN_X1000);
		end
		else
		begin
			q <= d;
		end
	end

	assign bus.cfg_wr       = q.cfg_wr;
	assign bus.cfg_ch       = q.cfg_ch;
	assign bus.cfg_grp      = q.cfg_grp;
	assign bus.init_done    = q.init_done;
	assign bus.host_led_req = q.led_req;
	assign bus.key_stb      = q.key_stb;
	assign bus.key          = q.key;
	assign bus.rd_en        = q.rd_en;
	assign bus.rd_addr      = q.rd_addr;
	assign rd_data_out      = q.rd_data;
	assign rd_ack_out       = q.rd_ack;
	assign fault_led        = q.fault_led;
	assign lag_tau_out      = q.lag_tau;
endmodule : rtdsc_host

// ### testbench/rtdsc_asserts.sv
module rtdsc_asserts (
	input wire logic        clock,        // Clock
	input wire logic        resetn,       // Reset
	input wire logic        init_done,    // Host init done
	input wire logic        host_led_req, // Host lamp request
	input wire logic        key_stb,      // Key strobe
	input wire logic        rd_en,        // Read request
	input wire logic [3:0]  rd_addr,      // Slot address
	input wire logic [15:0] rd_data,      // Slot data
	input wire logic        rd_ack,       // Read answer
	input wire logic        fault_led     // Lamp
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// ========
	// Helper
	logic key_seen_q;
	logic key_seen_d;

	always_comb
	begin
		key_seen_d = key_seen_q | key_stb;
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
			key_seen_q <= 1'b0;
		else
			key_seen_q <= key_seen_d;
	end

	sequence s_read_done;
		rd_en ##1 rd_ack;
	endsequence

	// ========
	// Checks
	a_read_ack_next: assert property (rd_en |=> rd_ack)
		else $error("read not answered next cycle");
	a_ack_has_cause: assert property (rd_ack |-> $past(rd_en))
		else $error("answer without read");
	a_ack_one_cycle: assert property (s_read_done |=> !rd_ack || $past(rd_en))
		else $error("answer held too long");
	a_status_upper_zero: assert property (rd_en && rd_addr[0] |=> rd_data[15:1] == 15'h0000)
		else $error("status slot upper bits set");
	a_temp_before_key: assert property (!key_seen_d && rd_en && !rd_addr[0] |=> rd_data == 16'h0000)
		else $error("temperature written without key");
	a_led_after_reset: assert property ($rose(resetn) |-> fault_led)
		else $error("lamp off after reset");
	a_led_wait_init: assert property (!init_done |-> fault_led)
		else $error("lamp off before init");
	a_led_host_req: assert property ($past(host_led_req) |-> fault_led)
		else $error("lamp off while host requests it");
endmodule : rtdsc_asserts

// ### testbench/rtd_input_scan_compensation_tb.sv
module rtd_input_scan_compensation_tb;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {logic [2:0] ch; logic [13:0] code; logic [15:0] temp;} rtdsc_row_s;

	// ========
	// Signals
	logic        clock, resetn, conv_start, fault_led, rd_ack_out;
	logic        adc_valid = 1'b0;
	logic        cfg_wr_in, init_go, diag_done, diag_pass, key_stb_in, rd_en_in;
	logic [2:0]  chan_sel, cfg_ch_in, cfg_grp_in;
	logic [1:0]  ref_sel;
	logic [13:0] adc_data = 14'h0000;
	logic [7:0]  key_in;
	logic [3:0]  rd_addr_in;
	logic [15:0] rd_data_out, lag_tau_in, lag_tau_out, seen;
	logic [13:0] ref_a [8];
	logic [13:0] ref_b [8];
	logic [13:0] raw [8];
	logic [2:0]  order [$];
	int          n_mismatch;
	int          n_compared;
	rtdsc_row_s  rows [8] = '{'{3'h0, 14'h0000, 16'hF6D7}, '{3'h1, 14'h0F00, 16'hFE71},
		'{3'h2, 14'h1400, 16'h00FA}, '{3'h3, 14'h1401, 16'h00FA}, '{3'h4, 14'h1402, 16'h00FB},
		'{3'h5, 14'h2940, 16'h0BBF}, '{3'h6, 14'h3FC0, 16'h1726}, '{3'h7, 14'h3FFF, 16'h1745}};

	rtdsc_if bus_if ();
	rtdsc_dev #(.CAL_PERIOD_CYC(2000)) i_rtdsc_dev (.clock(clock), .resetn(resetn), .bus(bus_if),
		.chan_sel(chan_sel), .ref_sel(ref_sel), .conv_start(conv_start), .adc_valid(adc_valid),
		.adc_data(adc_data));
	rtdsc_host i_rtdsc_host (.clock(clock), .resetn(resetn), .bus(bus_if), .cfg_wr_in(cfg_wr_in),
		.cfg_ch_in(cfg_ch_in), .cfg_grp_in(cfg_grp_in), .init_go(init_go), .diag_done(diag_done),
		.diag_pass(diag_pass), .key_stb_in(key_stb_in), .key_in(key_in), .rd_en_in(rd_en_in),
		.rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out), .rd_ack_out(rd_ack_out),
		.fault_led(fault_led), .lag_tau_in(lag_tau_in), .lag_tau_out(lag_tau_out));
	rtdsc_asserts i_rtdsc_asserts (.clock(clock), .resetn(resetn), .init_done(bus_if.init_done),
		.host_led_req(bus_if.host_led_req), .key_stb(bus_if.key_stb), .rd_en(bus_if.rd_en),
		.rd_addr(bus_if.rd_addr), .rd_data(bus_if.rd_data), .rd_ack(bus_if.rd_ack),
		.fault_led(bus_if.fault_led));

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ========
	// Converter, four cycles per conversion
	always @(posedge clock)
	begin
		if (conv_start)
		begin
			repeat (4) @(posedge clock);
			#1;
			adc_data = (ref_sel == rtdsc_pkg::SEL_REF_A) ? ref_a[chan_sel] :
				(ref_sel == rtdsc_pkg::SEL_REF_B) ? ref_b[chan_sel] : raw[chan_sel];
			adc_valid = 1'b1;
			@(posedge clock);
			#1;
			adc_valid = 1'b0;
			adc_data = ~adc_data;
		end
	end

	always @(posedge clock)
	begin
		if (conv_start && ref_sel == rtdsc_pkg::SEL_INPUT)
			order.push_back(chan_sel);
	end

	// ========
	// Tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic read_slot(input logic [3:0] addr, output logic [15:0] data);
		int i;
		rd_en_in = 1'b1;
		rd_addr_in = addr;
		tick(1);
		rd_en_in = 1'b0;
		for (i = 0; i < 20 && rd_ack_out !== 1'b1; i++)
			tick(1);
		check(16'(i < 20), 16'h0001);
		data = rd_data_out;
	endtask : read_slot

	task automatic send_key(input logic [7:0] k);
		key_in = k;
		key_stb_in = 1'b1;
		tick(1);
		key_stb_in = 1'b0;
		tick(1);
	endtask : send_key

	task automatic wait_conv(input logic [1:0] sel, input logic [2:0] ch);
		int i;
		for (i = 0; i < 3000 && !(conv_start === 1'b1 && ref_sel === sel && chan_sel === ch); i++)
			tick(1);
		check(16'(i < 3000), 16'h0001);
		tick(50);
	endtask : wait_conv

	task automatic final_report();
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	initial
	begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		final_report();
	end

	// ========
	// Main sequence
	initial
	begin
		{resetn, cfg_wr_in, init_go, diag_done, diag_pass, key_stb_in, rd_en_in} = '0;
		{cfg_ch_in, cfg_grp_in, key_in, rd_addr_in} = '0;
		lag_tau_in = 16'h0064;
		n_mismatch = 0;
		n_compared = 0;
		foreach (raw[i])
		begin
			ref_a[i] = rtdsc_pkg::REF_A_NOM;
			ref_b[i] = rtdsc_pkg::REF_B_NOM;
			raw[i] = 14'h0000;
		end
		tick(2);
		resetn = 1'b1;
		read_slot(4'h0, seen);
		check(seen, 16'h0000);
		read_slot(4'h1, seen);
		check(seen, 16'h0000);
		check(16'(fault_led), 16'h0001);
		check(lag_tau_out, 16'h00C8);
		lag_tau_in = 16'h01F4;
		tick(2);
		check(lag_tau_out, 16'h01F4);
		for (int c = 0; c < 8; c++)
		begin
			cfg_ch_in = 3'(c);
			cfg_grp_in = (c == 7) ? 3'h6 : 3'(c);
			cfg_wr_in = 1'b1;
			tick(1);
			cfg_wr_in = 1'b0;
			tick(1);
		end
		tick(400);
		diag_pass = 1'b1;
		diag_done = 1'b1;
		tick(1);
		diag_done = 1'b0;
		tick(5);
		check(16'(fault_led), 16'h0001);
		init_go = 1'b1;
		tick(1);
		init_go = 1'b0;
		tick(5);
		check(16'(fault_led), 16'h0000);
		foreach (rows[r])
		begin
			raw[rows[r].ch] = rows[r].code;
			send_key(8'h01 << ((rows[r].ch == 3'h7) ? 3'h6 : rows[r].ch));
			wait_conv(rtdsc_pkg::SEL_INPUT, rows[r].ch);
			read_slot({rows[r].ch, 1'b0}, seen);
			check(seen, rows[r].temp);
		end
		order.delete();
		send_key(8'h24);
		wait_conv(rtdsc_pkg::SEL_INPUT, 3'h5);
		send_key(8'h80);
		tick(100);
		check(16'(order.size()), 16'h0002);
		check(16'(order[0]), 16'h0002);
		check(16'(order[1]), 16'h0005);
		ref_a[3] = 14'h1201;
		ref_a[0] = 14'h1100;
		ref_b[0] = 14'h2900;
		wait_conv(rtdsc_pkg::SEL_REF_B, 3'h7);
		read_slot(4'h7, seen);
		check(seen, 16'h0001);
		check(16'(fault_led), 16'h0000);
		ref_a[3] = 14'h1200;
		raw[0] = 14'h1400;
		wait_conv(rtdsc_pkg::SEL_REF_B, 3'h7);
		read_slot(4'h7, seen);
		check(seen, 16'h0000);
		send_key(8'h01);
		wait_conv(rtdsc_pkg::SEL_INPUT, 3'h0);
		read_slot(4'h0, seen);
		check(seen, 16'h0078);
		// Second reset in mid-run: lamp back on, slots cleared
		resetn = 1'b0;
		tick(2);
		resetn = 1'b1;
		check(16'(fault_led), 16'h0001);
		read_slot(4'h0, seen);
		check(seen, 16'h0000);
		final_report();
	end
endmodule : rtd_input_scan_compensation_tb
